// ===== rtl/uaf_pkg.sv
package uaf_pkg;

    // ****************************************
    // bus shape
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFF_CTRL_ONE   = 8'h00;
    localparam logic [7:0] OFF_CTRL_THREE = 8'h08;
    localparam logic [7:0] OFF_STATUS     = 8'h1c;
    localparam logic [7:0] OFF_CLEAR      = 8'h20;

    localparam logic [31:0] CTRL_ONE_RST   = 32'h0000_0000;
    localparam logic [31:0] CTRL_THREE_RST = 32'h0000_0000;

    // ****************************************
    // control_reg_one fields
    // ****************************************
    localparam int C1_STOP_WAKE = 1;
    localparam int C1_RX_NOT_EMPTY_FLAG_IE   = 5;
    localparam int C1_TC_IE     = 6;
    localparam int C1_PE_IE     = 8;
    localparam int C1_OVER8     = 15;
    localparam int C1_DRIVER_DEASSERT_TIME_LO   = 16;
    localparam int C1_DRIVER_ASSERT_TIME_LO   = 21;
    localparam int TIME_W       = 5;

    // ****************************************
    // control_reg_three fields
    // ****************************************
    localparam int C3_ERR_IE    = 0;
    localparam int C3_RX_DMA    = 6;
    localparam int C3_TX_DMA    = 7;
    localparam int C3_RTS_EN    = 8;
    localparam int C3_CTS_EN    = 9;
    localparam int C3_CTS_IE    = 10;
    localparam int C3_DE_MODE   = 14;
    localparam int C3_DE_POL    = 15;
    localparam int C3_WUS_LO    = 20;
    localparam int C3_WUF_IE    = 22;

    // ****************************************
    // status and clear bit positions
    // ****************************************
    localparam int ST_PE   = 0;
    localparam int ST_FE   = 1;
    localparam int ST_NF   = 2;
    localparam int ST_ORE  = 3;
    localparam int ST_RX_NOT_EMPTY_FLAG = 5;
    localparam int ST_TC   = 6;
    localparam int ST_TXE  = 7;
    localparam int ST_CTSF = 9;
    localparam int ST_CTS  = 10;
    localparam int ST_WUF  = 20;

    // ****************************************
    // wake source encodings
    // ****************************************
    localparam logic [1:0] WUS_ADDR  = 2'h0;
    localparam logic [1:0] WUS_START = 2'h2;
    localparam logic [1:0] WUS_RX_NOT_EMPTY_FLAG  = 2'h3;

    typedef enum logic [1:0] {
        TX_IDLE, TX_LEAD, TX_BUSY, TX_TAIL
    } uaf_tx_state_t;

    typedef enum logic [1:0] {
        WK_IDLE, WK_REQ, WK_AWAKE
    } uaf_wk_state_t;

endpackage

// ===== rtl/uaf_flow_ctrl.sv
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Function
// - rx and tx dma requests are produced independently of each other.
// - with tx dma enabled, request a write whenever tx data register is empty.
// - with rx dma enabled, request a read whenever a received byte waits.
// - tx complete stays clear during transfers, set after the last frame.
// - software clears tx complete by writing one to its clear bit.
// - multibuffer errors flag after the current byte, interrupt when enabled.
// - framing, overrun, noise errors interrupt via their own error enable.
// - rts and cts flow control each have an independent enable.
// - rts low while receiver can accept, high once receive register is full.
// - with cts flow on, a new frame starts only while cts is low.
// - cts rising mid-frame lets the current frame finish before halting.
// - with cts flow on, every cts toggle sets the cts change flag, interrupt when enabled.
// - driver enable leads start bit and trails stop bit by 5-bit counts.
// - driver enable is active high with the polarity bit clear, active low with it set.
// - driver enable counts are in sample periods of the oversampling.
// - in stop, a falling rx edge requests the fast clock when it is off.
// - no qualifying event releases the request; a qualifying one wakes.
// - slow clock, when selected, is gated off in stop except while requested.
// - the selected wake event sets the wakeup flag, interrupt when enabled.
// - stop wake source is rx not empty with its interrupt enabled, or the selected wake event.
// - start-bit wake sets the wakeup flag and leaves rx not empty alone.
module uaf_flow_ctrl (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        tx_pending,
    input  wire logic        tx_frame_done,
    output logic             tx_start,
    input  wire logic        rx_full,
    input  wire logic        rx_byte_end,
    input  wire logic        err_frame,
    input  wire logic        err_overrun,
    input  wire logic        err_noise,
    input  wire logic        err_parity,
    input  wire logic        addr_match,
    input  wire logic        sample_tick,
    output logic             over8,
    output logic             tx_dma_req,
    output logic             rx_dma_req,
    input  wire logic        cts_pin,
    output logic             rts_pin,
    output logic             driver_enable_out,
    input  wire logic        rx_pin,
    input  wire logic        stop_mode,
    input  wire logic        fast_osc_on,
    input  wire logic        slow_osc_selected,
    output logic             fast_osc_req,
    output logic             slow_clk_en,
    output logic             wake_sys,
    output logic             irq
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic                  stop_mode_wake_enable;
        logic                  rx_not_empty_irq_enable;
        logic                  tc_irq_enable;
        logic                  parity_irq_enable;
        logic                  over8;
        logic [4:0]            driver_deassert_time;
        logic [4:0]            driver_assert_time;
        logic                  error_irq_enable;
        logic                  rx_dma_enable;
        logic                  tx_dma_enable;
        logic                  rts_flow_enable;
        logic                  cts_flow_enable;
        logic                  cts_change_irq_enable;
        logic                  driver_enable_mode;
        logic                  driver_enable_polarity;
        logic [1:0]            wakeup_source_select;
        logic                  wakeup_irq_enable;
        logic                  tx_complete_flag;
        logic                  cts_change_flag;
        logic                  wakeup_flag;
        logic                  err_fe;
        logic                  err_ore;
        logic                  err_nf;
        logic                  err_pe;
        logic                  cts_s1;
        logic                  cts_s2;
        logic                  cts_prev;
        logic                  rx_s1;
        logic                  rx_s2;
        logic                  rx_prev;
        uaf_pkg::uaf_tx_state_t tx_state;
        uaf_pkg::uaf_wk_state_t wk_state;
        logic [4:0]            cnt;
        logic                  tx_start;
        logic                  tx_dma_req;
        logic                  rx_dma_req;
        logic                  rts;
        logic                  de;
        logic                  fast_req;
        logic                  slow_en;
        logic                  wake;
        logic                  irq;
        logic [31:0]           rdata;
    } uaf_state_t;

    uaf_state_t q;
    uaf_state_t next_q;
    logic       rx_fall;
    logic       cts_ok;
    logic       wuf_evt;
    logic       wake_evt;
    logic [31:0] ctrl_one;
    logic [31:0] ctrl_three;
    logic [31:0] status;

    // ****************************************
    // register images
    // ****************************************
    always_comb begin
        ctrl_one = '0;
        ctrl_one[uaf_pkg::C1_STOP_WAKE] = q.stop_mode_wake_enable;
        ctrl_one[uaf_pkg::C1_RX_NOT_EMPTY_FLAG_IE]   = q.rx_not_empty_irq_enable;
        ctrl_one[uaf_pkg::C1_TC_IE]     = q.tc_irq_enable;
        ctrl_one[uaf_pkg::C1_PE_IE]     = q.parity_irq_enable;
        ctrl_one[uaf_pkg::C1_OVER8]     = q.over8;
        ctrl_one[uaf_pkg::C1_DRIVER_DEASSERT_TIME_LO +: uaf_pkg::TIME_W] =
            q.driver_deassert_time;
        ctrl_one[uaf_pkg::C1_DRIVER_ASSERT_TIME_LO +: uaf_pkg::TIME_W] =
            q.driver_assert_time;
        ctrl_three = '0;
        ctrl_three[uaf_pkg::C3_ERR_IE]  = q.error_irq_enable;
        ctrl_three[uaf_pkg::C3_RX_DMA]  = q.rx_dma_enable;
        ctrl_three[uaf_pkg::C3_TX_DMA]  = q.tx_dma_enable;
        ctrl_three[uaf_pkg::C3_RTS_EN]  = q.rts_flow_enable;
        ctrl_three[uaf_pkg::C3_CTS_EN]  = q.cts_flow_enable;
        ctrl_three[uaf_pkg::C3_CTS_IE]  = q.cts_change_irq_enable;
        ctrl_three[uaf_pkg::C3_DE_MODE] = q.driver_enable_mode;
        ctrl_three[uaf_pkg::C3_DE_POL]  = q.driver_enable_polarity;
        ctrl_three[uaf_pkg::C3_WUS_LO +: 2] = q.wakeup_source_select;
        ctrl_three[uaf_pkg::C3_WUF_IE]  = q.wakeup_irq_enable;
        status = '0;
        status[uaf_pkg::ST_PE]   = q.err_pe;
        status[uaf_pkg::ST_FE]   = q.err_fe;
        status[uaf_pkg::ST_NF]   = q.err_nf;
        status[uaf_pkg::ST_ORE]  = q.err_ore;
        status[uaf_pkg::ST_RX_NOT_EMPTY_FLAG] = rx_full;
        status[uaf_pkg::ST_TC]   = q.tx_complete_flag;
        status[uaf_pkg::ST_TXE]  = ~tx_pending;
        status[uaf_pkg::ST_CTSF] = q.cts_change_flag;
        status[uaf_pkg::ST_CTS]  = q.cts_s2;
        status[uaf_pkg::ST_WUF]  = q.wakeup_flag;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_q = q;
        next_q.tx_start = 1'b0;
        // pins from the far side: two flops before any use
        next_q.cts_s1   = cts_pin;
        next_q.cts_s2   = q.cts_s1;
        next_q.cts_prev = q.cts_s2;
        next_q.rx_s1    = rx_pin;
        next_q.rx_s2    = q.rx_s1;
        next_q.rx_prev  = q.rx_s2;
        rx_fall = q.rx_prev & ~q.rx_s2;
        cts_ok  = ~q.cts_flow_enable | ~q.cts_s2;

        case (q.wakeup_source_select)
            uaf_pkg::WUS_START: wuf_evt = rx_fall;
            uaf_pkg::WUS_RX_NOT_EMPTY_FLAG:  wuf_evt = rx_byte_end;
            uaf_pkg::WUS_ADDR:  wuf_evt = addr_match;
            default:            wuf_evt = addr_match;
        endcase
        wake_evt = wuf_evt | (rx_full & q.rx_not_empty_irq_enable);

        if (reg_rd) begin
            case (reg_addr)
                uaf_pkg::OFF_CTRL_ONE:   next_q.rdata = ctrl_one;
                uaf_pkg::OFF_CTRL_THREE: next_q.rdata = ctrl_three;
                uaf_pkg::OFF_STATUS:     next_q.rdata = status;
                default:                 next_q.rdata = '0;
            endcase
        end

        if (reg_wr && reg_addr == uaf_pkg::OFF_CTRL_ONE) begin
            next_q.stop_mode_wake_enable =
                reg_wdata[uaf_pkg::C1_STOP_WAKE];
            next_q.rx_not_empty_irq_enable =
                reg_wdata[uaf_pkg::C1_RX_NOT_EMPTY_FLAG_IE];
            next_q.tc_irq_enable     = reg_wdata[uaf_pkg::C1_TC_IE];
            next_q.parity_irq_enable = reg_wdata[uaf_pkg::C1_PE_IE];
            next_q.over8             = reg_wdata[uaf_pkg::C1_OVER8];
            next_q.driver_deassert_time =
                reg_wdata[uaf_pkg::C1_DRIVER_DEASSERT_TIME_LO +: uaf_pkg::TIME_W];
            next_q.driver_assert_time =
                reg_wdata[uaf_pkg::C1_DRIVER_ASSERT_TIME_LO +: uaf_pkg::TIME_W];
        end
        if (reg_wr && reg_addr == uaf_pkg::OFF_CTRL_THREE) begin
            next_q.error_irq_enable  = reg_wdata[uaf_pkg::C3_ERR_IE];
            next_q.rx_dma_enable     = reg_wdata[uaf_pkg::C3_RX_DMA];
            next_q.tx_dma_enable     = reg_wdata[uaf_pkg::C3_TX_DMA];
            next_q.rts_flow_enable   = reg_wdata[uaf_pkg::C3_RTS_EN];
            next_q.cts_flow_enable   = reg_wdata[uaf_pkg::C3_CTS_EN];
            next_q.cts_change_irq_enable = reg_wdata[uaf_pkg::C3_CTS_IE];
            next_q.driver_enable_mode = reg_wdata[uaf_pkg::C3_DE_MODE];
            next_q.driver_enable_polarity = reg_wdata[uaf_pkg::C3_DE_POL];
            next_q.wakeup_source_select =
                reg_wdata[uaf_pkg::C3_WUS_LO +: 2];
            next_q.wakeup_irq_enable = reg_wdata[uaf_pkg::C3_WUF_IE];
        end

        // clears first, so a same-cycle set below wins
        if (reg_wr && reg_addr == uaf_pkg::OFF_CLEAR) begin
            if (reg_wdata[uaf_pkg::ST_TC]) begin
                next_q.tx_complete_flag = 1'b0;
            end
            if (reg_wdata[uaf_pkg::ST_CTSF]) begin
                next_q.cts_change_flag = 1'b0;
            end
            if (reg_wdata[uaf_pkg::ST_WUF]) begin
                next_q.wakeup_flag = 1'b0;
            end
            if (reg_wdata[uaf_pkg::ST_PE]) begin
                next_q.err_pe = 1'b0;
            end
            if (reg_wdata[uaf_pkg::ST_FE]) begin
                next_q.err_fe = 1'b0;
            end
            if (reg_wdata[uaf_pkg::ST_NF]) begin
                next_q.err_nf = 1'b0;
            end
            if (reg_wdata[uaf_pkg::ST_ORE]) begin
                next_q.err_ore = 1'b0;
            end
        end

        // errors land with the end of the byte that carried them
        if (rx_byte_end) begin
            next_q.err_fe  = q.err_fe | err_frame;
            next_q.err_ore = q.err_ore | err_overrun;
            next_q.err_nf  = q.err_nf | err_noise;
            next_q.err_pe  = q.err_pe | err_parity;
        end
        if (q.cts_flow_enable && (q.cts_s2 != q.cts_prev)) begin
            next_q.cts_change_flag = 1'b1;
        end
        if (wuf_evt) begin
            next_q.wakeup_flag = 1'b1;
        end
        if (tx_frame_done && !tx_pending) begin
            next_q.tx_complete_flag = 1'b1;
        end

        // ****************************************
        // transmit sequencing and driver enable
        // ****************************************
        case (q.tx_state)
            uaf_pkg::TX_IDLE: begin
                // cts only looked at between frames
                if (tx_pending && cts_ok) begin
                    next_q.cnt = '0;
                    if (q.driver_enable_mode) begin
                        next_q.tx_state = uaf_pkg::TX_LEAD;
                    end else begin
                        next_q.tx_state = uaf_pkg::TX_BUSY;
                        next_q.tx_start = 1'b1;
                    end
                end
            end
            uaf_pkg::TX_LEAD: begin
                if (q.cnt == q.driver_assert_time) begin
                    next_q.tx_state = uaf_pkg::TX_BUSY;
                    next_q.tx_start = 1'b1;
                end else if (sample_tick) begin
                    next_q.cnt = q.cnt + 5'h01;
                end
            end
            uaf_pkg::TX_BUSY: begin
                if (tx_frame_done) begin
                    next_q.cnt = '0;
                    next_q.tx_state = q.driver_enable_mode ?
                        uaf_pkg::TX_TAIL : uaf_pkg::TX_IDLE;
                end
            end
            uaf_pkg::TX_TAIL: begin
                // new data waits for the full tail and a fresh lead
                if (q.cnt == q.driver_deassert_time) begin
                    next_q.tx_state = uaf_pkg::TX_IDLE;
                end else if (sample_tick) begin
                    next_q.cnt = q.cnt + 5'h01;
                end
            end
            default: next_q.tx_state = uaf_pkg::TX_IDLE;
        endcase

        // ****************************************
        // stop mode wake
        // ****************************************
        case (q.wk_state)
            uaf_pkg::WK_IDLE: begin
                if (stop_mode && q.stop_mode_wake_enable) begin
                    if (wake_evt) begin
                        next_q.wk_state = uaf_pkg::WK_AWAKE;
                    end else if (rx_fall && !fast_osc_on) begin
                        next_q.wk_state = uaf_pkg::WK_REQ;
                    end
                end
            end
            uaf_pkg::WK_REQ: begin
                if (wake_evt) begin
                    next_q.wk_state = uaf_pkg::WK_AWAKE;
                end else if (rx_byte_end || !stop_mode) begin
                    next_q.wk_state = uaf_pkg::WK_IDLE;
                end
            end
            uaf_pkg::WK_AWAKE: begin
                if (!stop_mode) begin
                    next_q.wk_state = uaf_pkg::WK_IDLE;
                end
            end
            default: next_q.wk_state = uaf_pkg::WK_IDLE;
        endcase

        // ****************************************
        // registered outputs
        // ****************************************
        next_q.tx_dma_req = next_q.tx_dma_enable & ~tx_pending;
        next_q.rx_dma_req = next_q.rx_dma_enable & rx_full;
        next_q.rts = next_q.rts_flow_enable & rx_full;
        next_q.de = (next_q.driver_enable_mode &&
                     next_q.tx_state != uaf_pkg::TX_IDLE) ?
                    ~next_q.driver_enable_polarity :
                    next_q.driver_enable_polarity;
        next_q.fast_req = next_q.wk_state != uaf_pkg::WK_IDLE;
        next_q.wake = next_q.wk_state == uaf_pkg::WK_AWAKE;
        // gating saves power while asleep and idle
        next_q.slow_en = ~slow_osc_selected | ~stop_mode |
                         next_q.fast_req;
        next_q.irq =
            (next_q.tx_complete_flag & next_q.tc_irq_enable) |
            (next_q.cts_change_flag & next_q.cts_change_irq_enable) |
            (next_q.wakeup_flag & next_q.wakeup_irq_enable) |
            (rx_full & next_q.rx_not_empty_irq_enable) |
            (next_q.err_pe & next_q.parity_irq_enable) |
            ((next_q.err_fe | next_q.err_ore | next_q.err_nf) &
             next_q.error_irq_enable);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (en) begin
            q <= next_q;
        end
    end

    assign reg_rdata         = q.rdata;
    assign tx_start          = q.tx_start;
    assign over8             = q.over8;
    assign tx_dma_req        = q.tx_dma_req;
    assign rx_dma_req        = q.rx_dma_req;
    assign rts_pin           = q.rts;
    assign driver_enable_out = q.de;
    assign fast_osc_req      = q.fast_req;
    assign slow_clk_en       = q.slow_en;
    assign wake_sys          = q.wake;
    assign irq               = q.irq;

    // ****************************************
    // checks
    // ****************************************
    property p_tx_dma;
        @(posedge clk) disable iff (!rstn)
        (en && !reg_wr && q.tx_dma_enable && !tx_pending) |=> tx_dma_req;
    endproperty
    a_tx_dma: assert property (p_tx_dma) else $error("tx dma missing");

    property p_rx_dma;
        @(posedge clk) disable iff (!rstn)
        (en && !reg_wr && q.rx_dma_enable && rx_full) |=> rx_dma_req;
    endproperty
    a_rx_dma: assert property (p_rx_dma) else $error("rx dma missing");

    property p_tc_set;
        @(posedge clk) disable iff (!rstn)
        (en && tx_frame_done && !tx_pending) |=> q.tx_complete_flag;
    endproperty
    a_tc_set: assert property (p_tc_set) else $error("tc not set");

    property p_tc_clr;
        @(posedge clk) disable iff (!rstn)
        (en && reg_wr && reg_addr == uaf_pkg::OFF_CLEAR &&
         reg_wdata[uaf_pkg::ST_TC] && !tx_frame_done)
        |=> !q.tx_complete_flag;
    endproperty
    a_tc_clr: assert property (p_tc_clr) else $error("tc not cleared");

    property p_cts_hold;
        @(posedge clk) disable iff (!rstn)
        (en && q.cts_flow_enable && q.cts_s2 &&
         q.tx_state == uaf_pkg::TX_IDLE) |=> !tx_start;
    endproperty
    a_cts_hold: assert property (p_cts_hold) else $error("sent on cts");

    property p_cts_flag;
        @(posedge clk) disable iff (!rstn)
        (en && q.cts_flow_enable && q.cts_s2 != q.cts_prev)
        |=> q.cts_change_flag;
    endproperty
    a_cts_flag: assert property (p_cts_flag) else $error("cts flag");

    property p_de_level;
        @(posedge clk) disable iff (!rstn)
        (en && !reg_wr && q.driver_enable_mode &&
         q.tx_state == uaf_pkg::TX_BUSY && !tx_frame_done)
        |=> driver_enable_out == !q.driver_enable_polarity;
    endproperty
    a_de_level: assert property (p_de_level) else $error("de level");

    property p_wake_req;
        @(posedge clk) disable iff (!rstn)
        (en && stop_mode && q.stop_mode_wake_enable && rx_fall &&
         !fast_osc_on && q.wk_state == uaf_pkg::WK_IDLE)
        |=> fast_osc_req;
    endproperty
    a_wake_req: assert property (p_wake_req) else $error("no clk req");

    property p_rts;
        @(posedge clk) disable iff (!rstn)
        (en && !reg_wr && q.rts_flow_enable && rx_full) |=> rts_pin;
    endproperty
    a_rts: assert property (p_rts) else $error("rts low when full");

endmodule

`default_nettype wire

// ===== test/uaf_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// shift stage model: load fills, frame ends DLY cycles after start
// ****
module uaf_peer #(parameter int DLY = 12) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic load,
    input  wire logic tx_start,
    output logic      tx_pending,
    output logic      tx_frame_done
);
    int cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_pending <= 1'b0;
            tx_frame_done <= 1'b0;
            cnt <= 0;
        end else begin
            tx_frame_done <= (cnt == 1);
            if (cnt > 0)
                cnt <= cnt - 1;
            if (tx_start) begin
                tx_pending <= 1'b0;
                cnt <= DLY;
            end else if (load)
                tx_pending <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== test/uaf_flow_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module uaf_flow_ctrl_tb_top;
    logic clk = 0, rstn = 0, en = 1, wr = 0, rd = 0, load = 0, tick = 0;
    logic rx_full = 0, cts = 0, rx = 1, stop = 0, fosc = 0, slow = 0;
    logic bend = 0, ferr = 0;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata, v;
    logic pend, done, start, txd, rxd, rts, de, freq, sclk, wake, irq;
    int n_errors = 0, checked = 0, i;
    always #2.5 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    uaf_peer peer (.clk(clk), .rstn(rstn), .load(load), .tx_start(start),
        .tx_pending(pend), .tx_frame_done(done));
    uaf_flow_ctrl uut (.clk(clk), .rstn(rstn), .en(en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .tx_pending(pend), .tx_frame_done(done), .tx_start(start),
        .rx_full(rx_full), .rx_byte_end(bend), .err_frame(ferr),
        .err_overrun(1'b0), .err_noise(1'b0), .err_parity(1'b0),
        .addr_match(1'b0), .sample_tick(tick), .over8(),
        .tx_dma_req(txd), .rx_dma_req(rxd), .cts_pin(cts), .rts_pin(rts),
        .driver_enable_out(de), .rx_pin(rx), .stop_mode(stop),
        .fast_osc_on(fosc), .slow_osc_selected(slow),
        .fast_osc_req(freq), .slow_clk_en(sclk), .wake_sys(wake), .irq(irq));
    // ****
    // bus and compare helpers
    // ****
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 v = rdata;
    endtask
    task summarize;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task t_dma;
        wr_reg(uaf_pkg::OFF_CTRL_THREE, 32'h0000_01c0);
        rx_full <= 1;
        repeat (4) @(negedge clk);
        chk({txd, rxd, rts}, 3'h7);
        wr_reg(8'h44, 32'hffff_ffff);
        rd_reg(8'h44);
        chk(v, 32'h0);
        // a write while en is low must not reach the control bits
        @(posedge clk);
        en <= 0;
        wr_reg(uaf_pkg::OFF_CTRL_THREE, 32'h0000_0000);
        en <= 1;
        @(negedge clk);
        chk({txd, rxd, rts}, 3'h7);
        wr_reg(uaf_pkg::OFF_CTRL_THREE, 32'h0000_0040);
        repeat (3) @(negedge clk);
        chk({txd, rxd, rts}, 3'h2);
        @(posedge clk);
        rx_full <= 0;
    endtask
    task t_tx;
        wr_reg(uaf_pkg::OFF_CTRL_THREE, 32'h0000_0200);
        cts <= 1;
        wr_reg(uaf_pkg::OFF_CLEAR, 32'h0000_0240);
        load <= 1;
        @(posedge clk);
        load <= 0;
        for (i = 0; i < 12 && start !== 1'b1; i++) @(negedge clk);
        chk(start, 1'b0);
        @(posedge clk);
        cts <= 0;
        for (i = 0; i < 12 && start !== 1'b1; i++) @(negedge clk);
        chk(start, 1'b1);
        rd_reg(uaf_pkg::OFF_STATUS);
        chk(v[6], 1'b0);
        for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk);
        rd_reg(uaf_pkg::OFF_STATUS);
        chk({v[6], v[9]}, 2'h3);
        wr_reg(uaf_pkg::OFF_CLEAR, 32'h0000_0240);
        rd_reg(uaf_pkg::OFF_STATUS);
        chk({v[6], v[9]}, 2'h0);
    endtask
    task t_de;
        wr_reg(uaf_pkg::OFF_CTRL_ONE, 32'h0062_0000);
        wr_reg(uaf_pkg::OFF_CTRL_THREE, 32'h0000_4000);
        load <= 1;
        @(posedge clk);
        load <= 0;
        for (i = 0; i < 8 && de !== 1'b1; i++) @(negedge clk);
        chk({de, start}, 2'h2);
        for (i = 0; i < 20 && start !== 1'b1; i++) @(negedge clk);
        chk({de, start, i > 3}, 3'h7);
        for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        chk(de, 1'b1);
        for (i = 0; i < 20 && de !== 1'b0; i++) @(negedge clk);
        chk({de, i > 0}, 2'h1);
        wr_reg(uaf_pkg::OFF_CTRL_THREE, 32'h0000_c000);
        @(negedge clk);
        chk(de, 1'b1);
    endtask
    task t_wake;
        wr_reg(uaf_pkg::OFF_CTRL_ONE, 32'h0000_0002);
        wr_reg(uaf_pkg::OFF_CTRL_THREE, 32'h0000_0001);
        stop <= 1;
        slow <= 1;
        rx <= 0;
        repeat (2) @(negedge clk);
        chk(sclk, 1'b0);
        for (i = 0; i < 8 && freq !== 1'b1; i++) @(negedge clk);
        chk({freq, wake, sclk}, 3'h5);
        // byte ends with no address match: request must drop
        @(posedge clk);
        bend <= 1;
        ferr <= 1;
        @(posedge clk);
        bend <= 0;
        ferr <= 0;
        rx <= 1;
        @(negedge clk);
        chk({freq, wake, sclk, irq}, 4'h1);
        wr_reg(uaf_pkg::OFF_CTRL_THREE, 32'h0060_0000);
        rx <= 0;
        for (i = 0; i < 8 && wake !== 1'b1; i++) @(negedge clk);
        chk({freq, wake, sclk, irq}, 4'hf);
        rd_reg(uaf_pkg::OFF_STATUS);
        chk({v[20], v[5]}, 2'h2);
        @(posedge clk);
        stop <= 0;
        rx <= 1;
        repeat (2) @(negedge clk);
        chk({freq, wake}, 2'h0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1;
        t_dma;
        t_tx;
        t_de;
        t_wake;
        summarize;
    end
    initial begin
        #100us;
        n_errors++;
        summarize;
    end
endmodule
`default_nettype wire
